/* File: core/ccds_readout_ctrl.v */
`timescale 1ns/1ps
`include "ccds_defines.vh"
// Summary of operation
// R1: Tag first 28 pixels after the dummies of each line as dark.
// R2: Tag first 29 and last 26 lines of every frame as dark.
// R3: Tag 20 leading dummy pixels; never counted as dark reference.
// R4: Tag 16 buffer pixels around active area as non-guaranteed data.
// R5: First 4 buffer columns are blue, others follow the colour mosaic.
// R6: Vertical phases held low for the whole exposure.
// R7: Line transfer on falling vertical phase two, horizontal phase one high.
// R8: Dual split reads at once; parallel split pulses transfer gate.
// R9: Each line read split at midpoint, left and right halves together.
// R10: One sample per falling edge of the last horizontal gate.
// R11: One transfer gate signal drives both halves.
// R12: Flush: phase two high, phase one low, then pulse flush gate.
// R13: Dump gate pulsed in the same vertical-phase condition.
// R14: Drain complete only after phase two low plus settle time.
// R15: Reset gate set after each sample, cleared at the next read step; stays high while idle after a frame.
// R16: Counters span 7410 pixels by 5566 lines plus overclock.
// R17: Active region 7304 by 5478 inside the total array.
// R18: Overclock adds 140 pixels per line and 178 lines per frame.
// R19: Pixel and line counters tag every sample with its class.
// R20: Frame runs flush, exposure, then line transfer and readout.
module ccds_readout_ctrl #(
   parameter EXPOSE_CYC  = 825000,
   parameter SETTLE_CYC  = `CCDS_SETTLE_CYC,
   parameter OVER_PIX    = `CCDS_OVER_PIX,
   parameter OVER_LINES  = `CCDS_OVER_LINES,
   parameter DATA_W      = 16
) (
   // Clock and reset
   input  wire              CORE_CLK,
   input  wire              RESET,
   // Control
   input  wire              START,
   input  wire              PARALLEL_SPLIT,
   output wire              BUSY,
   // Sensor phase pins
   output reg               VERTICAL_PHASE_ONE,
   output reg               VERTICAL_PHASE_TWO,
   output reg               HORIZ_PHASE_ONE_A,
   output reg               LAST_HORIZONTAL_GATE,
   output reg               HORIZ_TRANSFER_GATE,
   output reg               ARRAY_FLUSH_GATE,
   output reg               ROW_DUMP_GATE,
   output reg               SENSE_RESET_GATE,
   // Front-end sampler
   input  wire [DATA_W-1:0] ADC_LEFT,
   input  wire [DATA_W-1:0] ADC_RIGHT,
   // Tagged pixel stream
   output wire              PIX_VALID,
   input  wire              PIX_READY,
   output wire [DATA_W-1:0] PIX_LEFT,
   output wire [DATA_W-1:0] PIX_RIGHT,
   output wire [1:0]        PIX_CLASS,
   output wire              PIX_BLUE
);
   localparam ST_IDLE   = 3'd0;
   localparam ST_FL_V2  = 3'd1;
   localparam ST_FL_PG  = 3'd2;
   localparam ST_FL_SET = 3'd3;
   localparam ST_EXPOSE = 3'd4;
   localparam ST_VXFER  = 3'd5;
   localparam ST_HREAD  = 3'd6;
   localparam [19:0] PH = `CCDS_PHASE_CYC;
   localparam W  = 2 * DATA_W + 3;
   localparam [12:0] HALF_PIX = (`CCDS_TOTAL_PIX + OVER_PIX) / 13'd2;
   localparam [12:0] LINES    = `CCDS_TOTAL_LINES + OVER_LINES;
   localparam [12:0] DK_END   = `CCDS_DUMMY_PIX + `CCDS_DARK_PIX;
   localparam [12:0] BF_END   = DK_END + `CCDS_BUFFER_PIX;
   localparam [12:0] ACT_END  = BF_END + `CCDS_ACTIVE_PIX / 13'd2;

   reg [2:0]  state_reg;
   reg [2:0]  state_next;
   reg [19:0] tmr_reg;
   reg [3:0]  step_reg;
   reg [12:0] pix_reg;
   reg [12:0] line_reg;
   reg [W-1:0] buf_mem [0:1];
   reg        wr_ptr_reg;
   reg        rd_ptr_reg;
   reg [1:0]  cnt_reg;

   function [1:0] ccds_class;
      input [12:0] px;
      input [12:0] ln;
      begin
         if (px < `CCDS_DUMMY_PIX)
            ccds_class = `CCDS_CLS_DUMMY; // R3
         else if (px < DK_END || ln < `CCDS_DARK_TOP ||
                  ln >= `CCDS_TOTAL_LINES - `CCDS_DARK_BOT ||
                  px >= HALF_PIX - `CCDS_DARK_PIX)
            ccds_class = `CCDS_CLS_DARK; // R1 R2
         else if (px < BF_END || px >= ACT_END ||
                  ln < `CCDS_DARK_TOP + `CCDS_BUFFER_PIX ||
                  ln >= `CCDS_DARK_TOP + `CCDS_BUFFER_PIX +
                        `CCDS_ACTIVE_LINES)
            ccds_class = `CCDS_CLS_BUFFER; // R4 R17
         else
            ccds_class = `CCDS_CLS_ACTIVE;
      end
   endfunction

   wire buf_full  = (cnt_reg == 2'd2);
   wire stall     = buf_full;
   wire tmr_done  = (tmr_reg == 20'd0);
   wire samp_now  = (state_reg == ST_HREAD) && tmr_done && !stall &&
                    (step_reg == 4'd1);
   wire push      = samp_now;
   wire pop       = PIX_VALID && PIX_READY;

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:   if (START) state_next = ST_FL_V2; // R20
         ST_FL_V2:  if (tmr_done) state_next = ST_FL_PG; // R12
         ST_FL_PG:  if (tmr_done) state_next = ST_FL_SET; // R13
         ST_FL_SET: if (tmr_done) state_next = ST_EXPOSE; // R14
         ST_EXPOSE: if (tmr_done) state_next = ST_VXFER; // R6
         ST_VXFER:  if (tmr_done && step_reg == 4'd3)
                       state_next = ST_HREAD;
         ST_HREAD:  if (samp_now && pix_reg == HALF_PIX - 13'd1)
                       state_next = (line_reg == LINES - 13'd1) ?
                                    ST_IDLE : ST_VXFER; // R16 R18
         default:   state_next = ST_IDLE;
      endcase
   end

   always @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         state_reg            <= ST_IDLE;
         tmr_reg              <= 20'd0;
         step_reg             <= 4'd0;
         pix_reg              <= 13'd0;
         line_reg             <= 13'd0;
         VERTICAL_PHASE_ONE   <= 1'b0;
         VERTICAL_PHASE_TWO   <= 1'b0;
         HORIZ_PHASE_ONE_A    <= 1'b0;
         LAST_HORIZONTAL_GATE <= 1'b0;
         HORIZ_TRANSFER_GATE  <= 1'b0;
         ARRAY_FLUSH_GATE     <= 1'b0;
         ROW_DUMP_GATE        <= 1'b0;
         SENSE_RESET_GATE     <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (!tmr_done && !(state_reg == ST_HREAD && stall))
            tmr_reg <= tmr_reg - 20'd1;
         case (state_reg)
            ST_IDLE: if (START) begin
               VERTICAL_PHASE_ONE <= 1'b0;
               VERTICAL_PHASE_TWO <= 1'b1; // R12
               line_reg           <= 13'd0;
               tmr_reg            <= PH;
            end
            ST_FL_V2: if (tmr_done) begin
               ARRAY_FLUSH_GATE <= 1'b1; // R12
               ROW_DUMP_GATE    <= 1'b1; // R13
               tmr_reg          <= PH;
            end
            ST_FL_PG: if (tmr_done) begin
               ARRAY_FLUSH_GATE   <= 1'b0;
               ROW_DUMP_GATE      <= 1'b0;
               VERTICAL_PHASE_TWO <= 1'b0; // R14
               tmr_reg            <= SETTLE_CYC[19:0]; // R14
            end
            ST_FL_SET: if (tmr_done) begin
               tmr_reg <= EXPOSE_CYC[19:0]; // R6
            end
            ST_EXPOSE: if (tmr_done) begin
               step_reg          <= 4'd0;
               HORIZ_PHASE_ONE_A <= 1'b1; // R7
               tmr_reg           <= PH;
            end
            ST_VXFER: if (tmr_done) begin
               step_reg <= step_reg + 4'd1;
               tmr_reg  <= PH;
               case (step_reg)
                  4'd0: VERTICAL_PHASE_ONE <= 1'b1;
                  4'd1: VERTICAL_PHASE_TWO <= 1'b1;
                  4'd2: begin
                     VERTICAL_PHASE_ONE <= 1'b0;
                     VERTICAL_PHASE_TWO <= 1'b0; // R7
                     // Parallel split: previous line moves to B register
                     HORIZ_TRANSFER_GATE <= PARALLEL_SPLIT; // R8 R11
                  end
                  default: begin
                     HORIZ_TRANSFER_GATE <= 1'b0;
                     step_reg <= 4'd0;
                     pix_reg  <= 13'd0;
                  end
               endcase
            end
            ST_HREAD: if (tmr_done && !stall) begin
               tmr_reg <= PH;
               case (step_reg)
                  4'd0: begin
                     SENSE_RESET_GATE     <= 1'b0;
                     LAST_HORIZONTAL_GATE <= 1'b1;
                     step_reg             <= 4'd1;
                  end
                  default: begin
                     LAST_HORIZONTAL_GATE <= 1'b0; // R10
                     SENSE_RESET_GATE     <= 1'b1; // R15
                     step_reg             <= 4'd0;
                     pix_reg              <= pix_reg + 13'd1; // R19
                     if (pix_reg == HALF_PIX - 13'd1) begin
                        line_reg          <= line_reg + 13'd1;
                        HORIZ_PHASE_ONE_A <= 1'b1; // R7
                     end
                  end
               endcase
            end
            default: ;
         endcase
      end
   end

   // Sample taken at the gate's falling edge; ADC is assumed settled then
   always @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         cnt_reg    <= 2'd0;
      end else begin
         if (push)
            wr_ptr_reg <= ~wr_ptr_reg;
         if (pop)
            rd_ptr_reg <= ~rd_ptr_reg;
         cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end

   wire [1:0] cls_now  = ccds_class(pix_reg, line_reg);
   wire       blue_now = (pix_reg >= DK_END) &&
                         (pix_reg < DK_END + `CCDS_BLUE_PIX); // R5

   always @(posedge CORE_CLK) begin
      if (push)
         // Both halves sampled together on the same gate edge
         buf_mem[wr_ptr_reg] <= {ADC_LEFT, ADC_RIGHT, cls_now,
                                 blue_now}; // R9
   end

   wire [W-1:0] head = buf_mem[rd_ptr_reg];
   assign PIX_VALID = (cnt_reg != 2'd0);
   assign PIX_LEFT  = PIX_VALID ? head[W-1:DATA_W+3] : {DATA_W{1'b0}};
   assign PIX_RIGHT = PIX_VALID ? head[DATA_W+2:3] : {DATA_W{1'b0}};
   assign PIX_CLASS = PIX_VALID ? head[2:1] : 2'h0;
   assign PIX_BLUE  = PIX_VALID ? head[0] : 1'b0;
   assign BUSY      = (state_reg != ST_IDLE);
endmodule

/* File: core/ccds_defines.vh */
`ifndef CCDS_DEFINES_VH
`define CCDS_DEFINES_VH
// Frame layout counts
`define CCDS_TOTAL_PIX    13'd7410
`define CCDS_TOTAL_LINES  13'd5566
`define CCDS_ACTIVE_PIX   13'd7304
`define CCDS_ACTIVE_LINES 13'd5478
`define CCDS_DARK_PIX     13'd28
`define CCDS_DUMMY_PIX    13'd20
`define CCDS_BUFFER_PIX   13'd16
`define CCDS_BLUE_PIX     13'd4
`define CCDS_DARK_TOP     13'd29
`define CCDS_DARK_BOT     13'd26
`define CCDS_OVER_PIX     13'd140
`define CCDS_OVER_LINES   13'd178
// Pixel class codes
`define CCDS_CLS_DARK     2'h0
`define CCDS_CLS_DUMMY    2'h1
`define CCDS_CLS_BUFFER   2'h2
`define CCDS_CLS_ACTIVE   2'h3
// Timing, in ns and converted to core clock cycles at 40 ns
`define CCDS_CLK_NS       40
`define CCDS_PHASE_NS     160
`define CCDS_PHASE_CYC    ((`CCDS_PHASE_NS + `CCDS_CLK_NS - 1) / `CCDS_CLK_NS)
`define CCDS_SETTLE_NS    1000
`define CCDS_SETTLE_CYC   ((`CCDS_SETTLE_NS + `CCDS_CLK_NS - 1) / `CCDS_CLK_NS)
`endif

/* File: tb/ccds_props.sv */
`timescale 1ns/1ps
module ccds_props #(
   parameter DATA_W = 16
) (
   // Clock, reset, control
   input wire              CORE_CLK,
   input wire              RESET,
   input wire              START,
   input wire              BUSY,
   // Sensor pins
   input wire              VERTICAL_PHASE_ONE,
   input wire              VERTICAL_PHASE_TWO,
   input wire              HORIZ_PHASE_ONE_A,
   input wire              LAST_HORIZONTAL_GATE,
   input wire              ARRAY_FLUSH_GATE,
   input wire              ROW_DUMP_GATE,
   input wire              SENSE_RESET_GATE,
   // Pixel stream
   input wire              PIX_VALID,
   input wire              PIX_READY,
   input wire [DATA_W-1:0] PIX_LEFT,
   input wire [1:0]        PIX_CLASS
);
   wire vph1 = VERTICAL_PHASE_ONE;
   wire vph2 = VERTICAL_PHASE_TWO;
   wire lg   = LAST_HORIZONTAL_GATE;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   // Flush ends with phase two falling while phase one stayed low
   sequence s_flush_end;
      $fell(vph2) && !$past(vph1);
   endsequence
   sequence s_line_edge;
      vph1 && vph2 ##1 !vph2;
   endsequence
   a_flush_cond: assert property (ARRAY_FLUSH_GATE |-> vph2 && !vph1)
      else $error("flush gate outside phase two");
   a_dump_cond: assert property (ROW_DUMP_GATE |-> vph2 && !vph1)
      else $error("dump gate outside phase two");
   a_line_edge: assert property (s_line_edge |-> HORIZ_PHASE_ONE_A)
      else $error("line moved without phase one a");
   a_expose_quiet: assert property (s_flush_end |-> (!vph1 && !vph2)[*8])
      else $error("vertical clocks moved during settle or exposure");
   a_reset_after: assert property ($fell(lg) |-> SENSE_RESET_GATE)
      else $error("sense reset missing after sample");
   a_reset_clear: assert property ($rose(lg) |-> !SENSE_RESET_GATE)
      else $error("sense reset held into next packet");
   // Checked where the fall is seen; a ready consumer may pop it next edge
   a_word_ready: assert property ($fell(lg) |-> PIX_VALID)
      else $error("no word after last gate edge");
   a_word_hold: assert property (PIX_VALID && !PIX_READY |=>
      PIX_VALID && $stable(PIX_LEFT) && $stable(PIX_CLASS))
      else $error("stalled word changed");
   a_start_busy: assert property (START && !BUSY |=> BUSY)
      else $error("frame did not start");
   a_idle_quiet: assert property (!BUSY |-> !vph1 && !vph2 && !lg)
      else $error("pins active while idle");
endmodule
bind ccds_readout_ctrl ccds_props #(.DATA_W(DATA_W)) u_props (
   .CORE_CLK(CORE_CLK), .RESET(RESET), .START(START), .BUSY(BUSY),
   .VERTICAL_PHASE_ONE(VERTICAL_PHASE_ONE),
   .VERTICAL_PHASE_TWO(VERTICAL_PHASE_TWO),
   .HORIZ_PHASE_ONE_A(HORIZ_PHASE_ONE_A),
   .LAST_HORIZONTAL_GATE(LAST_HORIZONTAL_GATE),
   .ARRAY_FLUSH_GATE(ARRAY_FLUSH_GATE), .ROW_DUMP_GATE(ROW_DUMP_GATE),
   .SENSE_RESET_GATE(SENSE_RESET_GATE), .PIX_VALID(PIX_VALID),
   .PIX_READY(PIX_READY), .PIX_LEFT(PIX_LEFT), .PIX_CLASS(PIX_CLASS));

/* File: tb/ccds_sensor_model.sv */
`timescale 1ns/1ps
module ccds_sensor_model (
   // Phase pins
   input  wire        VERTICAL_PHASE_ONE,
   input  wire        VERTICAL_PHASE_TWO,
   input  wire        LAST_HORIZONTAL_GATE,
   input  wire        HORIZ_TRANSFER_GATE,
   input  wire        ARRAY_FLUSH_GATE,
   input  wire        ROW_DUMP_GATE,
   // Sampled outputs
   output wire [15:0] ADC_LEFT,
   output wire [15:0] ADC_RIGHT
);
   integer     packet = 0;
   integer     faults = 0;
   integer     tg_pulses = 0;
   wire [15:0] lv = 16'(packet * 3 + 1);
   wire [15:0] rv = 16'(packet * 5 + 7);
   // Reset node shows the inverse so a late sample cannot pass
   assign ADC_LEFT = LAST_HORIZONTAL_GATE ? lv : ~lv;
   assign ADC_RIGHT = LAST_HORIZONTAL_GATE ? rv : ~rv;
   always @(posedge LAST_HORIZONTAL_GATE) packet = packet + 1;
   always @(posedge HORIZ_TRANSFER_GATE) tg_pulses = tg_pulses + 1;
   always @(posedge ARRAY_FLUSH_GATE or posedge ROW_DUMP_GATE) begin
      packet = 0;
      tg_pulses = 0;
      if (!VERTICAL_PHASE_TWO || VERTICAL_PHASE_ONE) faults = faults + 1;
   end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   reg         core_clk = 0;
   reg         reset = 1;
   reg         start = 0;
   reg         psplit = 0;
   reg         pix_ready = 0;
   reg  [15:0] lfsr = 16'hfa0d;
   wire [15:0] adc_l, adc_r, pix_l, pix_r;
   wire [1:0]  pix_class;
   wire        busy, pix_valid, pix_blue;
   wire        vph1, vph2, hph1a, lhg, htg, afg, dmp, srg;
   wire [7:0]  pins = {vph1, vph2, hph1a, lhg, htg, afg, dmp, srg};
   integer     miscompares = 0;
   integer     total_checks = 0;
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   ccds_readout_ctrl #(.EXPOSE_CYC(20), .SETTLE_CYC(2)) dut (
      .CORE_CLK(core_clk), .RESET(reset), .START(start),
      .PARALLEL_SPLIT(psplit), .BUSY(busy),
      .VERTICAL_PHASE_ONE(vph1), .VERTICAL_PHASE_TWO(vph2),
      .HORIZ_PHASE_ONE_A(hph1a), .LAST_HORIZONTAL_GATE(lhg),
      .HORIZ_TRANSFER_GATE(htg), .ARRAY_FLUSH_GATE(afg),
      .ROW_DUMP_GATE(dmp), .SENSE_RESET_GATE(srg),
      .ADC_LEFT(adc_l), .ADC_RIGHT(adc_r), .PIX_VALID(pix_valid),
      .PIX_READY(pix_ready), .PIX_LEFT(pix_l), .PIX_RIGHT(pix_r),
      .PIX_CLASS(pix_class), .PIX_BLUE(pix_blue));
   ccds_sensor_model sensor (
      .VERTICAL_PHASE_ONE(vph1), .VERTICAL_PHASE_TWO(vph2),
      .LAST_HORIZONTAL_GATE(lhg), .HORIZ_TRANSFER_GATE(htg),
      .ARRAY_FLUSH_GATE(afg), .ROW_DUMP_GATE(dmp),
      .ADC_LEFT(adc_l), .ADC_RIGHT(adc_r));
   function [15:0] lfsr_next(input [15:0] s);
      lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task tick;
      @(posedge core_clk);
      #1;
   endtask
   task chk_word(input string nm, input [15:0] e, input [15:0] g);
      total_checks = total_checks + 1;
      if (e !== g) begin
         miscompares = miscompares + 1;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task chk_flag(input string nm, input e, input g);
      chk_word(nm, {15'h0, e}, {15'h0, g});
   endtask
   task print_verdict;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk_class(input [1:0] e, input [1:0] g);
      chk_word("class", {14'h0, e}, {14'h0, g});
   endtask
   // Left-half class map of the frame layout; far columns are reached only in dark line 0
   function [1:0] exp_class(input integer px, input integer ln);
      if (px < 20)
         exp_class = 2'h1;
      else if (px < 20 + 28 || ln < 29 || ln >= 5566 - 26)
         exp_class = 2'h0;
      else if (px < 20 + 28 + 16 || ln < 29 + 16 || ln >= 29 + 16 + 5478)
         exp_class = 2'h2;
      else
         exp_class = 2'h3;
   endfunction
   // A frame up to a word count; the full array would take millions
   task run_frame(input ps, input integer nw, input integer nl);
      integer i, n, px, ln;
      reset = 1;
      repeat (16) tick;
      reset = 0;
      chk_flag("busy idle", 1'b0, busy);
      chk_word("pins idle", 16'h0, {8'h0, pins});
      psplit = ps;
      start = 1;
      tick;
      start = 0;
      chk_flag("busy run", 1'b1, busy);
      n = 0;
      for (i = 0; i < 50000 && n < nw; i = i + 1) begin
         lfsr = lfsr_next(lfsr);
         pix_ready = (i < 100 || i >= 160) ? lfsr[0] : 1'b0;
         if (pix_valid === 1'b1 && pix_ready) begin
            // Each line gives half its pixels as outputs, overclock included
            px = n % ((7410 + 140) / 2);
            ln = n / ((7410 + 140) / 2);
            chk_word("left", 16'((n + 1) * 3 + 1), pix_l);
            chk_word("right", 16'((n + 1) * 5 + 7), pix_r);
            chk_class(exp_class(px, ln), pix_class);
            chk_flag("blue", px >= 48 && px < 52, pix_blue);
            n = n + 1;
         end
         tick;
      end
      if (n < nw) begin
         miscompares = miscompares + 1;
         $display("CHECK FAILED words exp %0d got %0d", nw, n);
      end
      chk_word("tg pulses", 16'(ps * nl), 16'(sensor.tg_pulses));
      chk_word("pin faults", 16'h0, 16'(sensor.faults));
      $display("frame test split %0d done", ps);
   endtask
   initial begin
      run_frame(1'b0, 60, 1);
      run_frame(1'b1, 3835, 2);
      print_verdict;
   end
endmodule
